// *** core/fp_class_defines.vh ***
// Field layouts, biases and class encodings for the operand classifier.
// Assumes IEEE754-style binary32 and binary64 words presented by the issue stage.
`ifndef FP_CLASS_DEFINES_VH
`define FP_CLASS_DEFINES_VH

`define SP_WIDTH      32
`define DP_WIDTH      64
`define SP_EXP_WIDTH  8
`define DP_EXP_WIDTH  11
`define SP_FRAC_WIDTH 23
`define DP_FRAC_WIDTH 52
`define SP_PREC       24
`define DP_PREC       53
`define SP_BIAS       12'h07f
`define DP_BIAS       12'h3ff
`define SP_EMIN       (-13'sd126)
`define DP_EMIN       (-13'sd1022)
`define SP_SIGN_BIT   31
`define DP_SIGN_BIT   63
`define SP_EXP_LSB    23
`define DP_EXP_LSB    52
`define SP_EXP_MAX    11'h0ff
`define DP_EXP_MAX    11'h7ff

`define CLASS_WIDTH   6
`define CLASS_SIGNALING_NOT_A_NUMBER    6'h20
`define CLASS_QUIET_NOT_A_NUMBER    6'h10
`define CLASS_INF     6'h08
`define CLASS_NORM    6'h04
`define CLASS_DENORM  6'h02
`define CLASS_ZERO    6'h01

`define FREG_COUNT    32
`define FREG_ADDR_W   5
`define DREG_ADDR_W   4

`endif

// *** core/fp_operand_classifier.v ***
// Operand classifier with FPU-enable gate and the floating-point register file.
// Assumes the issue stage on the same clock drives the request and operand.
`include "fp_class_defines.vh"

module fp_operand_classifier (
	input  wire                      clk_i,
	input  wire                      arst_n_i,
	input  wire                      fpu_enable_status_bit_i,
	input  wire                      issue_valid_i,
	input  wire                      dbl_i,
	input  wire [`DP_WIDTH-1:0]      operand_i,
	output wire                      exec_valid_o,
	output wire                      disable_exc_o,
	output wire                      sign_o,
	output wire [`CLASS_WIDTH-1:0]   class_o,
	output wire signed [12:0]        true_exp_o,
	output wire [`DP_PREC-1:0]       significand_o,
	input  wire                      wr_en_i,
	input  wire                      wr_dbl_i,
	input  wire [`FREG_ADDR_W-1:0]   wr_addr_i,
	input  wire [`DP_WIDTH-1:0]      wr_data_i,
	input  wire                      rd_dbl_i,
	input  wire [`FREG_ADDR_W-1:0]   rd_addr_i,
	output wire [`DP_WIDTH-1:0]      rd_data_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Field extraction. Singles sit in the low 32 bits of the operand bus. Both
	// precisions are widened to an 11-bit exponent and a 52-bit fraction so one
	// classify function serves both; a single fraction is zero-filled at the bottom so
	// that its leading bit lands where a double's does.

	function field_sign;
		input                 d;
		input [`DP_WIDTH-1:0] w;
		begin
			if (d) begin
				field_sign = w[`DP_SIGN_BIT];
			end else begin
				field_sign = w[`SP_SIGN_BIT];
			end
		end
	endfunction

	function [`DP_EXP_WIDTH-1:0] field_exp;
		input                 d;
		input [`DP_WIDTH-1:0] w;
		begin
			if (d) begin
				field_exp = w[`DP_EXP_LSB +: `DP_EXP_WIDTH];
			end else begin
				field_exp = {3'h0, w[`SP_EXP_LSB +: `SP_EXP_WIDTH]};
			end
		end
	endfunction

	function [`DP_FRAC_WIDTH-1:0] field_frac;
		input                 d;
		input [`DP_WIDTH-1:0] w;
		begin
			if (d) begin
				field_frac = w[`DP_FRAC_WIDTH-1:0];
			end else begin
				field_frac = {w[`SP_FRAC_WIDTH-1:0], 29'h0};
			end
		end
	endfunction

	function [`DP_EXP_WIDTH-1:0] exp_ones;
		input d;
		begin
			if (d) begin
				exp_ones = `DP_EXP_MAX;
			end else begin
				exp_ones = `SP_EXP_MAX;
			end
		end
	endfunction

	function [`CLASS_WIDTH-1:0] classify;
		input [`DP_EXP_WIDTH-1:0]  e;
		input [`DP_FRAC_WIDTH-1:0] f;
		input [`DP_EXP_WIDTH-1:0]  emax;
		begin
			if (e == emax && f != 52'h0) begin
				// Top fraction bit set means signaling on this unit.
				classify = f[51] ? `CLASS_SIGNALING_NOT_A_NUMBER : `CLASS_QUIET_NOT_A_NUMBER;
			end else if (e == emax) begin
				classify = `CLASS_INF;
			end else if (e != 11'h0) begin
				classify = `CLASS_NORM;
			end else if (f != 52'h0) begin
				classify = `CLASS_DENORM;
			end else begin
				classify = `CLASS_ZERO;
			end
		end
	endfunction

	wire                      sign;
	wire [`DP_EXP_WIDTH-1:0]  exp_f;
	wire [`DP_FRAC_WIDTH-1:0] frac_f;
	wire [`DP_EXP_WIDTH-1:0]  exp_all_ones;
	wire [`CLASS_WIDTH-1:0]   cls;

	assign sign         = field_sign(dbl_i, operand_i);
	assign exp_f        = field_exp(dbl_i, operand_i);
	assign frac_f       = field_frac(dbl_i, operand_i);
	assign exp_all_ones = exp_ones(dbl_i);
	assign cls          = classify(exp_f, frac_f, exp_all_ones);

	////////////////////////////////////////////////////////////////////////////////
	// True exponent and significand. Denormals use the minimum exponent and a
	// hidden zero, so the exponent never reads one below the normal range.
	// The 13-bit signed width holds every unbiased double exponent with room.

	function signed [12:0] bias_of;
		input d;
		begin
			if (d) begin
				bias_of = $signed({1'b0, `DP_BIAS});
			end else begin
				bias_of = $signed({1'b0, `SP_BIAS});
			end
		end
	endfunction

	function signed [12:0] emin_of;
		input d;
		begin
			if (d) begin
				emin_of = `DP_EMIN;
			end else begin
				emin_of = `SP_EMIN;
			end
		end
	endfunction

	// 24-bit single significands are right aligned in the 53-bit bus.
	function [`DP_PREC-1:0] significand_of;
		input                      d;
		input                      h;
		input [`DP_FRAC_WIDTH-1:0] f;
		begin
			if (d) begin
				significand_of = {h, f};
			end else begin
				significand_of = {29'h0, h, f[`DP_FRAC_WIDTH-1 -: `SP_FRAC_WIDTH]};
			end
		end
	endfunction

	wire signed [12:0]  bias;
	wire signed [12:0]  emin;
	wire signed [12:0]  exp_wide;
	wire                hidden;
	reg  signed [12:0]  true_exp;
	reg  [`DP_PREC-1:0] significand;

	assign bias     = bias_of(dbl_i);
	assign emin     = emin_of(dbl_i);
	assign exp_wide = $signed({2'b00, exp_f});
	assign hidden   = (exp_f != 11'h0);

	always @* begin
		true_exp    = emin;
		significand = significand_of(dbl_i, hidden, frac_f);
		if (hidden) begin
			true_exp = exp_wide - bias;
		end
	end

	assign true_exp_o    = true_exp;
	assign significand_o = significand;

	////////////////////////////////////////////////////////////////////////////////
	// Enable gate: the disable exception replaces execution, never both. The
	// class is still shown on a refused issue so the trap handler can see it.

	reg                    exec_valid;
	reg                    disable_exc;
	reg [`CLASS_WIDTH-1:0] class_shown;

	always @* begin
		exec_valid  = 1'b0;
		disable_exc = 1'b0;
		class_shown = {`CLASS_WIDTH{1'b0}};
		case ({issue_valid_i, fpu_enable_status_bit_i})
			2'b11: begin
				exec_valid  = 1'b1;
				class_shown = cls;
			end
			2'b10: begin
				disable_exc = 1'b1;
				class_shown = cls;
			end
			default: begin
				class_shown = {`CLASS_WIDTH{1'b0}};
			end
		endcase
	end

	assign exec_valid_o  = exec_valid;
	assign disable_exc_o = disable_exc;
	assign sign_o        = sign;
	assign class_o       = class_shown;

	fp_reg_file #(
		.COUNT(`FREG_COUNT)
	) u_regs (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.wr_en_i  (wr_en_i),
		.wr_dbl_i (wr_dbl_i),
		.wr_addr_i(wr_addr_i),
		.wr_data_i(wr_data_i),
		.rd_dbl_i (rd_dbl_i),
		.rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o)
	);

endmodule

// *** core/fp_reg_file.v ***
// Floating-point register file: 32 single words, also read and written as 16 double pairs.
// Assumes a single clock; read data come out of registers one cycle after the address.
`include "fp_class_defines.vh"

module fp_reg_file #(
	parameter COUNT = `FREG_COUNT
) (
	input  wire                      clk_i,
	input  wire                      arst_n_i,
	input  wire                      wr_en_i,
	input  wire                      wr_dbl_i,
	input  wire [`FREG_ADDR_W-1:0]   wr_addr_i,
	input  wire [`DP_WIDTH-1:0]      wr_data_i,
	input  wire                      rd_dbl_i,
	input  wire [`FREG_ADDR_W-1:0]   rd_addr_i,
	output reg  [`DP_WIDTH-1:0]      rd_data_o
);

	reg [`SP_WIDTH-1:0] mem [0:COUNT-1];
	wire [`FREG_ADDR_W-1:0] wr_even = {wr_addr_i[`FREG_ADDR_W-1:1], 1'b0};
	wire [`FREG_ADDR_W-1:0] rd_even = {rd_addr_i[`FREG_ADDR_W-1:1], 1'b0};

	// A double pair is the even register (high word) and the odd one above it.
	always @(posedge clk_i) begin
		if (wr_en_i && wr_dbl_i) begin
			mem[wr_even]        <= wr_data_i[63:32];
			mem[wr_even | 5'h01] <= wr_data_i[31:0];
		end else if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i[31:0];
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= 64'h0;
		end else if (rd_dbl_i) begin
			rd_data_o <= {mem[rd_even], mem[rd_even | 5'h01]};
		end else begin
			rd_data_o <= {32'h0, mem[rd_addr_i]};
		end
	end

endmodule

// *** tb/fp_classifier_props.sv ***
// Port checker for the operand classifier.
// Assumes it is bound to the classifier and shares its defines header.
`include "fp_class_defines.vh"
module fp_classifier_props (
	input logic               clk_i,
	input logic               arst_n_i,
	input logic               fpu_enable_status_bit_i,
	input logic               issue_valid_i,
	input logic               dbl_i,
	input logic [63:0]        operand_i,
	input logic               exec_valid_o,
	input logic               disable_exc_o,
	input logic               sign_o,
	input logic [5:0]         class_o,
	input logic signed [12:0] true_exp_o
);
	timeunit 1ns;
	timeprecision 100ps;
	wire [7:0]  se = operand_i[30:23];
	wire [22:0] sf = operand_i[22:0];
	wire        s = issue_valid_i && !dbl_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////
	chk_gate_off: assert property (
		issue_valid_i && !fpu_enable_status_bit_i |-> disable_exc_o && !exec_valid_o)
		else $error("disabled issue not refused");
	chk_gate_on: assert property (
		issue_valid_i && fpu_enable_status_bit_i |-> exec_valid_o && !disable_exc_o)
		else $error("enabled issue refused");
	chk_idle_class: assert property (
		!issue_valid_i |-> class_o == 6'h00 && !exec_valid_o && !disable_exc_o)
		else $error("class shown while idle");
	chk_class_onehot: assert property (
		issue_valid_i |-> $onehot(class_o)) else $error("class not one-hot");
	chk_sp_nan: assert property (
		s && se == 8'hff && sf != 0 |-> class_o == (sf[22] ? `CLASS_SIGNALING_NOT_A_NUMBER : `CLASS_QUIET_NOT_A_NUMBER))
		else $error("single NaN wrong");
	chk_sp_inf: assert property (
		s && se == 8'hff && sf == 0 |-> class_o == `CLASS_INF && sign_o == operand_i[31])
		else $error("single infinity wrong");
	chk_sp_norm: assert property (
		s && se != 0 && se != 8'hff |-> class_o == `CLASS_NORM
		&& true_exp_o == $signed({5'h00, se}) - 13'sd127) else $error("single normal wrong");
	chk_sp_small: assert property (
		s && se == 0 |-> class_o == (sf != 0 ? `CLASS_DENORM : `CLASS_ZERO)
		&& true_exp_o == -13'sd126) else $error("single small wrong");
	chk_dp_top: assert property (
		issue_valid_i && dbl_i && operand_i[62:52] == 11'h7ff |-> class_o ==
		(operand_i[51:0] == 0 ? `CLASS_INF : operand_i[51] ? `CLASS_SIGNALING_NOT_A_NUMBER : `CLASS_QUIET_NOT_A_NUMBER))
		else $error("double special wrong");
endmodule

// *** tb/fp_issue_model.sv ***
// Issue-stage model that feeds operands to the classifier.
// Assumes the bench sets its request just after a rising edge.
module fp_issue_model (
	input  logic        clk_i,
	input  logic        req_i,
	input  logic        dbl_req_i,
	input  logic [63:0] word_i,
	output logic        issue_valid_o = 0,
	output logic        dbl_o = 0,
	output logic [63:0] operand_o = '0
);
	timeunit 1ns;
	timeprecision 100ps;
	// An idle bus inverts its previous value each cycle, so the last word shows again every second idle cycle.
	always @(posedge clk_i) begin
		issue_valid_o <= #1 req_i;
		dbl_o <= #1 dbl_req_i;
		operand_o <= #1 req_i ? word_i : ~operand_o;
	end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the operand classifier and its register file.
// Assumes the issue model in front of the classifier inputs.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, arst_n_i = 0, en = 1, req = 0, rdbl = 0, wdbl = 0, wen = 0, dq = 0;
	logic [4:0] wa = '0, ra = '0;
	logic [63:0] wd = '0, w = '0, op, rd;
	logic iv, dbl, ev, exc, sgn;
	logic [5:0] cls;
	logic signed [12:0] te;
	logic [52:0] sig;
	int fails = 0, compares = 0;
	localparam logic [31:0] SW [10] = '{32'h7f800000, 32'hff800000, 32'h00800000,
		32'h7f7fffff, 32'h80000001, 32'h807fffff, 32'h80000000, 32'h7fc00000,
		32'h7fbfffff, 32'h7f800001};
	localparam logic [5:0] SC [10] = '{6'h08, 6'h08, 6'h04, 6'h04, 6'h02, 6'h02, 6'h01,
		6'h20, 6'h10, 6'h10};
	fp_issue_model u_mdl (.clk_i(clk_i), .req_i(req), .dbl_req_i(dq), .word_i(w),
		.issue_valid_o(iv), .dbl_o(dbl), .operand_o(op));
	fp_operand_classifier dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.fpu_enable_status_bit_i(en), .issue_valid_i(iv), .dbl_i(dbl), .operand_i(op),
		.exec_valid_o(ev), .disable_exc_o(exc), .sign_o(sgn), .class_o(cls),
		.true_exp_o(te), .significand_o(sig), .wr_en_i(wen), .wr_dbl_i(wdbl),
		.wr_addr_i(wa), .wr_data_i(wd), .rd_dbl_i(rdbl), .rd_addr_i(ra), .rd_data_o(rd));
	initial forever #5 clk_i = ~clk_i;
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task issue(input logic e, input logic d, input logic [63:0] x);
		@(posedge clk_i);
		#1 {en, req, dq, w} = {e, 1'b1, d, x};
		@(posedge clk_i);
		#1 req = 0;
		#2;
	endtask
	////////////////////////////////////////////////////////////////
	task t_single;
		for (int i = 0; i < 10; i++) begin
			issue(1, 0, {32'h0, SW[i]});
			chk(cls, SC[i]);
			chk(sgn, SW[i][31]);
		end
		issue(1, 0, 64'h00800000);
		chk(sig, 53'h800000);
		chk($unsigned(te), 13'h1f82);
	endtask
	task t_double;
		issue(0, 1, 64'hfff8000000000000);
		chk({ev, exc, sgn, cls}, 9'h0e0);
		issue(1, 1, 64'h0010000000000000);
		chk({ev, exc, cls}, 8'h84);
		chk($unsigned(te), 13'h1c02);
		chk(sig, 53'h10000000000000);
	endtask
	task t_regs;
		@(posedge clk_i);
		#1 {wen, wdbl, wa, wd} = {2'b10, 5'h05, 64'hffffffff12345678};
		@(posedge clk_i);
		#1 {wdbl, wa, wd} = {1'b1, 5'h02, 64'haaaa55550f0f1234};
		@(posedge clk_i);
		#1 {wen, rdbl, ra} = {2'b00, 5'h03};
		@(posedge clk_i);
		#1 chk(rd, 64'h0f0f1234);
		{rdbl, ra} = {1'b1, 5'h02};
		@(posedge clk_i);
		#1 chk(rd, 64'haaaa55550f0f1234);
		{rdbl, ra} = {1'b0, 5'h05};
		@(posedge clk_i);
		#1 chk(rd, 64'h12345678);
	endtask
	initial begin
		#21 arst_n_i = 1;
		t_single;
		t_double;
		t_regs;
		give_verdict;
	end
	initial begin
		#5000;
		fails++;
		give_verdict;
	end
endmodule
bind fp_operand_classifier fp_classifier_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.fpu_enable_status_bit_i(fpu_enable_status_bit_i), .issue_valid_i(issue_valid_i),
	.dbl_i(dbl_i), .operand_i(operand_i), .exec_valid_o(exec_valid_o),
	.disable_exc_o(disable_exc_o), .sign_o(sign_o), .class_o(class_o),
	.true_exp_o(true_exp_o));
